// *** mpwm_params.svh ***
// constants for the motion pwm module: offsets, fields, resets, encodings
`ifndef MPWM_PARAMS_SVH
`define MPWM_PARAMS_SVH

// global register byte offsets
`define MPWM_OFF_MCTL 12'h000
`define MPWM_OFF_SYNC 12'h004
`define MPWM_OFF_GUPD 12'h008
`define MPWM_OFF_OUTEN 12'h00c
`define MPWM_OFF_INV 12'h010
`define MPWM_OFF_FSEL 12'h014
`define MPWM_OFF_STAT 12'h018

// generator g sits at 0x040 * (g + 1); offsets within a generator
`define MPWM_G_CTL 6'h00
`define MPWM_G_LOAD 6'h04
`define MPWM_G_COUNT 6'h08
`define MPWM_G_CMPA 6'h0c
`define MPWM_G_CMPB 6'h10
`define MPWM_G_ACTA 6'h14
`define MPWM_G_ACTB 6'h18
`define MPWM_G_DBCTL 6'h1c
`define MPWM_G_DBRISE 6'h20
`define MPWM_G_DBFALL 6'h24
`define MPWM_G_INTEN 6'h28
`define MPWM_G_ISC 6'h2c

// status field positions
`define MPWM_STAT_FAULT_STICKY 8
`define MPWM_STAT_FAULT_PIN 9
`define MPWM_STAT_PEND_LSB 16

// action encodings, two bits per event
`define MPWM_ACT_NONE 2'h0
`define MPWM_ACT_INVERT 2'h1
`define MPWM_ACT_LOW 2'h2
`define MPWM_ACT_HIGH 2'h3

// reset values
`define MPWM_RST_LOAD 16'hffff
`define MPWM_RST_CMP 16'h0000
`define MPWM_RST_ACT 12'h000
`define MPWM_RST_DB 12'h000

`endif

// *** mpwm_pkg.sv ***
// types shared by the motion pwm module files
package mpwm_pkg;

  typedef struct packed {
    logic cbd;
    logic cbu;
    logic cad;
    logic cau;
    logic load;
    logic zero;
  } mpwm_evt_type;

  typedef struct packed {
    logic dcmpb;
    logic dcmpa;
    logic dload;
    logic updn;
    logic en;
  } mpwm_gctl_type;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } mpwm_dir_type;

endpackage

// *** mpwm_gen.sv ***
// one generator: counter, period and comparator values with deferred update
`include "mpwm_params.svh"
module mpwm_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire mpwm_pkg::mpwm_gctl_type ctl,
  input wire logic gmode,
  input wire logic gcmd,
  input wire logic restart,
  // value writes: 0 load, 1 cmpa, 2 cmpb
  input wire logic [2:0] wr,
  input wire logic [15:0] wdata,
  // state
  output logic [15:0] count,
  output logic [15:0] load,
  output logic [15:0] cmpa,
  output logic [15:0] cmpb,
  output logic [2:0] pend,
  output mpwm_pkg::mpwm_evt_type evt
);
  logic [15:0] val [3];
  logic [15:0] pval [3];
  logic [2:0] armed;
  logic [2:0] defer;
  logic sync_pt;
  logic up_dir;
  mpwm_pkg::mpwm_dir_type dir;

  assign defer = {ctl.dcmpb, ctl.dcmpa, ctl.dload};
  assign sync_pt = ctl.en && (count == 16'h0000);
  assign load = val[0];
  assign cmpa = val[1];
  assign cmpb = val[2];

  // a second write while pending replaces the value and keeps it pending
  always_ff @(posedge clk) begin
    if (rst) begin
      val[0] <= `MPWM_RST_LOAD;
      val[1] <= `MPWM_RST_CMP;
      val[2] <= `MPWM_RST_CMP;
      for (int i = 0; i < 3; i++) begin
        pval[i] <= 16'h0000;
      end
      pend <= 3'h0;
      armed <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr[i] && !defer[i]) begin
          val[i] <= wdata;
          pend[i] <= 1'b0;
        end else if (wr[i]) begin
          pval[i] <= wdata;
          pend[i] <= 1'b1;
          armed[i] <= 1'b0;
        end else if (pend[i] && sync_pt && (armed[i] || !gmode)) begin
          val[i] <= pval[i];
          pend[i] <= 1'b0;
          armed[i] <= 1'b0;
        end else if (pend[i] && gcmd) begin
          armed[i] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 16'h0000;
      dir <= mpwm_pkg::DIR_UP;
    end else if (restart) begin
      count <= ctl.updn ? 16'h0000 : val[0];
      dir <= mpwm_pkg::DIR_UP;
    end else if (ctl.en && !ctl.updn) begin
      count <= (count == 16'h0000) ? val[0] : count - 16'h0001;
      dir <= mpwm_pkg::DIR_DOWN;
    end else if (ctl.en) begin
      case (dir)
        mpwm_pkg::DIR_UP: begin
          if (count >= val[0]) begin
            dir <= mpwm_pkg::DIR_DOWN;
            count <= (count == 16'h0000) ? 16'h0000 : count - 16'h0001;
          end else begin
            count <= count + 16'h0001;
          end
        end
        mpwm_pkg::DIR_DOWN: begin
          if (count == 16'h0000) begin
            dir <= mpwm_pkg::DIR_UP;
            count <= (val[0] == 16'h0000) ? 16'h0000 : 16'h0001;
          end else begin
            count <= count - 16'h0001;
          end
        end
        default: begin
          dir <= mpwm_pkg::DIR_UP;
        end
      endcase
    end
  end

  assign up_dir = ctl.updn && (dir == mpwm_pkg::DIR_UP);
  assign evt.zero = ctl.en && (count == 16'h0000);
  assign evt.load = ctl.en && (count == val[0]);
  assign evt.cau = ctl.en && (count == val[1]) && up_dir;
  assign evt.cad = ctl.en && (count == val[1]) && !up_dir;
  assign evt.cbu = ctl.en && (count == val[2]) && up_dir;
  assign evt.cbd = ctl.en && (count == val[2]) && !up_dir;
endmodule

// *** mpwm_top.sv ***
// motion pwm module top: ahb-lite registers, builders, dead-band, output stage
`include "mpwm_params.svh"
module mpwm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // power stage
  input wire logic fault_in,
  output logic [5:0] pwm_out,
  // converter start requests
  output logic [2:0] adc_trig
);
  // bus phase state
  logic ap_valid;
  logic ap_write;
  logic [11:0] ap_addr;
  logic wr_en;
  logic [31:0] rdat;

  // global configuration
  logic [2:0] gmode;
  logic [5:0] outen;
  logic [5:0] invert;
  logic [5:0] fsel;
  logic fault_sticky;
  logic [2:0] restart;
  logic gcmd;

  // per generator configuration and state
  mpwm_pkg::mpwm_gctl_type gctl [3];
  logic [11:0] act_a [3];
  logic [11:0] act_b [3];
  logic [2:0] db_en;
  logic [11:0] db_rise [3];
  logic [11:0] db_fall [3];
  logic [13:0] inten [3];
  logic [5:0] isc [3];
  logic [15:0] cnt_w [3];
  logic [15:0] ld_w [3];
  logic [15:0] ca_w [3];
  logic [15:0] cb_w [3];
  logic [2:0] pend_w [3];
  mpwm_pkg::mpwm_evt_type evt [3];
  logic [5:0] raw;

  function automatic logic gen_hit(input logic [11:0] a, input logic [1:0] g);
    return (a[11:8] == 4'h0) && (a[7:6] == (g + 2'h1));
  endfunction

  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    case (act)
      `MPWM_ACT_INVERT: r = !cur;
      `MPWM_ACT_LOW: r = 1'b0;
      `MPWM_ACT_HIGH: r = 1'b1;
      default: r = cur;
    endcase
    return r;
  endfunction

  // later events in the list win when several fire in one cycle
  function automatic logic wave_step(input logic cur, input logic [11:0] acts, input logic [5:0] ev);
    logic r;
    r = cur;
    for (int k = 0; k < 6; k++) begin
      if (ev[k]) begin
        r = apply_act(r, acts[2*k +: 2]);
      end
    end
    return r;
  endfunction

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_en = ap_valid && ap_write;

  // address phase capture; zero wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 12'h000;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr <= haddr[11:0];
    end
  end

  // global configuration and one-cycle commands
  always_ff @(posedge clk) begin
    if (rst) begin
      gmode <= 3'h0;
      outen <= 6'h00;
      invert <= 6'h00;
      fsel <= 6'h00;
      restart <= 3'h0;
      gcmd <= 1'b0;
    end else begin
      restart <= 3'h0;
      gcmd <= 1'b0;
      if (wr_en) begin
        case (ap_addr)
          `MPWM_OFF_MCTL: gmode <= hwdata[2:0];
          `MPWM_OFF_SYNC: restart <= hwdata[2:0];
          `MPWM_OFF_GUPD: gcmd <= hwdata[0];
          `MPWM_OFF_OUTEN: outen <= hwdata[5:0];
          `MPWM_OFF_INV: invert <= hwdata[5:0];
          `MPWM_OFF_FSEL: fsel <= hwdata[5:0];
          default: gcmd <= 1'b0;
        endcase
      end
    end
  end

  // per generator configuration registers
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        gctl[i] <= '0;
        act_a[i] <= `MPWM_RST_ACT;
        act_b[i] <= `MPWM_RST_ACT;
        db_rise[i] <= `MPWM_RST_DB;
        db_fall[i] <= `MPWM_RST_DB;
        inten[i] <= 14'h0000;
      end
      db_en <= 3'h0;
    end else if (wr_en) begin
      for (int i = 0; i < 3; i++) begin
        if (gen_hit(ap_addr, 2'(i))) begin
          case (ap_addr[5:0])
            `MPWM_G_CTL: gctl[i] <= hwdata[4:0];
            `MPWM_G_ACTA: act_a[i] <= hwdata[11:0];
            `MPWM_G_ACTB: act_b[i] <= hwdata[11:0];
            `MPWM_G_DBCTL: db_en[i] <= hwdata[0];
            `MPWM_G_DBRISE: db_rise[i] <= hwdata[11:0];
            `MPWM_G_DBFALL: db_fall[i] <= hwdata[11:0];
            `MPWM_G_INTEN: inten[i] <= hwdata[13:0];
            default: db_en[i] <= db_en[i];
          endcase
        end
      end
    end
  end

  // sticky event status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        isc[i] <= 6'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en && gen_hit(ap_addr, 2'(i)) && (ap_addr[5:0] == `MPWM_G_ISC)) begin
          isc[i] <= (isc[i] & ~hwdata[5:0]) | (evt[i] & inten[i][5:0]);
        end else begin
          isc[i] <= isc[i] | (evt[i] & inten[i][5:0]);
        end
      end
    end
  end

  // converter start request, one pulse per selected event cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_trig <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        adc_trig[i] <= |(evt[i] & inten[i][13:8]);
      end
    end
  end

  // fault latch for software; the pins never wait for it
  always_ff @(posedge clk) begin
    if (rst) begin
      fault_sticky <= 1'b0;
    end else if (fault_in) begin
      fault_sticky <= 1'b1;
    end else if (wr_en && (ap_addr == `MPWM_OFF_STAT) && hwdata[`MPWM_STAT_FAULT_STICKY]) begin
      fault_sticky <= 1'b0;
    end
  end

  for (genvar g = 0; g < 3; g++) begin : gen_blk
    logic [2:0] wr_val;
    logic wa;
    logic wb;
    logic db_prev;
    logic db_wait;
    logic [11:0] db_cnt;
    logic dba;
    logic dbb;

    assign wr_val[0] = wr_en && gen_hit(ap_addr, 2'(g)) && (ap_addr[5:0] == `MPWM_G_LOAD);
    assign wr_val[1] = wr_en && gen_hit(ap_addr, 2'(g)) && (ap_addr[5:0] == `MPWM_G_CMPA);
    assign wr_val[2] = wr_en && gen_hit(ap_addr, 2'(g)) && (ap_addr[5:0] == `MPWM_G_CMPB);

    mpwm_gen u_gen (
      .clk(clk),
      .rst(rst),
      .ctl(gctl[g]),
      .gmode(gmode[g]),
      .gcmd(gcmd),
      .restart(restart[g]),
      .wr(wr_val),
      .wdata(hwdata[15:0]),
      .count(cnt_w[g]),
      .load(ld_w[g]),
      .cmpa(ca_w[g]),
      .cmpb(cb_w[g]),
      .pend(pend_w[g]),
      .evt(evt[g])
    );

    // waveform builder
    always_ff @(posedge clk) begin
      if (rst) begin
        wa <= 1'b0;
        wb <= 1'b0;
      end else begin
        wa <= wave_step(wa, act_a[g], evt[g]);
        wb <= wave_step(wb, act_b[g], evt[g]);
      end
    end

    // dead-band: both legs low during the delay; delay is setting plus one cycle
    always_ff @(posedge clk) begin
      if (rst) begin
        db_prev <= 1'b0;
        db_wait <= 1'b0;
        db_cnt <= 12'h000;
        dba <= 1'b0;
        dbb <= 1'b0;
      end else begin
        db_prev <= wa;
        if (wa && !db_prev) begin
          dbb <= 1'b0;
          db_cnt <= db_rise[g];
          db_wait <= 1'b1;
        end else if (!wa && db_prev) begin
          dba <= 1'b0;
          db_cnt <= db_fall[g];
          db_wait <= 1'b1;
        end else if (db_wait) begin
          if (db_cnt == 12'h000) begin
            db_wait <= 1'b0;
            if (wa) begin
              dba <= 1'b1;
            end else begin
              dbb <= 1'b1;
            end
          end else begin
            db_cnt <= db_cnt - 12'h001;
          end
        end
      end
    end

    assign raw[2*g +: 2] = db_en[g] ? {dbb, dba} : {wb, wa};
  end

  // output stage; fault acts on the raw pin, so one edge after fault rises
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_out <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (fault_in && fsel[i]) begin
          pwm_out[i] <= 1'b0;
        end else begin
          pwm_out[i] <= outen[i] && (raw[i] ^ invert[i]);
        end
      end
    end
  end

  // read mux, sampled in the address phase
  always_comb begin
    rdat = 32'h0000_0000;
    case (haddr[11:0])
      `MPWM_OFF_MCTL: rdat[2:0] = gmode;
      `MPWM_OFF_OUTEN: rdat[5:0] = outen;
      `MPWM_OFF_INV: rdat[5:0] = invert;
      `MPWM_OFF_FSEL: rdat[5:0] = fsel;
      `MPWM_OFF_STAT: begin
        rdat[2:0] = {|isc[2], |isc[1], |isc[0]};
        rdat[`MPWM_STAT_FAULT_STICKY] = fault_sticky;
        rdat[`MPWM_STAT_FAULT_PIN] = fault_in;
        rdat[`MPWM_STAT_PEND_LSB +: 3] = {|pend_w[2], |pend_w[1], |pend_w[0]};
      end
      default: rdat = 32'h0000_0000;
    endcase
    for (int i = 0; i < 3; i++) begin
      if (gen_hit(haddr[11:0], 2'(i))) begin
        case (haddr[5:0])
          `MPWM_G_CTL: rdat[4:0] = gctl[i];
          `MPWM_G_LOAD: rdat[15:0] = ld_w[i];
          `MPWM_G_COUNT: rdat[15:0] = cnt_w[i];
          `MPWM_G_CMPA: rdat[15:0] = ca_w[i];
          `MPWM_G_CMPB: rdat[15:0] = cb_w[i];
          `MPWM_G_ACTA: rdat[11:0] = act_a[i];
          `MPWM_G_ACTB: rdat[11:0] = act_b[i];
          `MPWM_G_DBCTL: rdat[0] = db_en[i];
          `MPWM_G_DBRISE: rdat[11:0] = db_rise[i];
          `MPWM_G_DBFALL: rdat[11:0] = db_fall[i];
          `MPWM_G_INTEN: rdat[13:0] = inten[i];
          `MPWM_G_ISC: rdat[5:0] = isc[i];
          default: rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  // back-to-back read after write to the same word sees the old value
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rdat;
    end
  end
endmodule

// *** mpwm_sva.sv ***
// checker on the motion pwm top ports
`include "mpwm_params.svh"
module mpwm_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // power stage side
  input wire logic fault_in,
  input wire logic [5:0] pwm_out,
  input wire logic [2:0] adc_trig
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_go;
  logic wr_q;
  logic [11:0] wa_q;
  logic [5:0] fsel;
  logic [5:0] outen;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  // shadow masks move on the same edge as the registers; $past picks the mask the pins used
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      fsel <= 6'h00;
      outen <= 6'h00;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wa_q <= haddr[11:0];
      if (wr_q && wa_q == `MPWM_OFF_FSEL) fsel <= hwdata[5:0];
      if (wr_q && wa_q == `MPWM_OFF_OUTEN) outen <= hwdata[5:0];
    end
  end
  sequence s_rd;
    rd_go;
  endsequence
  sequence s_rd_cmd;
    s_rd ##0 (haddr[11:0] == `MPWM_OFF_SYNC || haddr[11:0] == `MPWM_OFF_GUPD);
  endsequence
  sequence s_rd_hole;
    s_rd ##0 (haddr[11:0] >= 12'h100);
  endsequence
  a_ready_always: assert property (hreadyout == 1'b1) else $error("hreadyout low");
  a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> pwm_out == 6'h00 && adc_trig == 3'h0 && hrdata == 32'h0000_0000)
    else $error("outputs not quiet in reset");
  a_rdata_holds: assert property (!rd_go |=> $stable(hrdata)) else $error("hrdata moved without read");
  a_cmd_reads_zero: assert property (s_rd_cmd |=> hrdata == 32'h0000_0000) else $error("command word read nonzero");
  a_hole_reads_zero: assert property (s_rd_hole |=> hrdata == 32'h0000_0000) else $error("unmapped read nonzero");
  a_fault_off: assert property (fault_in |=> (pwm_out & $past(fsel)) == 6'h00) else $error("fault output active");
  a_disabled_off: assert property ((pwm_out & ~$past(outen)) == 6'h00) else $error("disabled output active");
endmodule
bind mpwm_top mpwm_sva u_sva (
  .clk(clk),
  .rst(rst),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .fault_in(fault_in),
  .pwm_out(pwm_out),
  .adc_trig(adc_trig)
);

// *** mpwm_stage.sv ***
// power stage model: fault sense and half-bridge overlap watch
module mpwm_stage (
  // clock
  input wire logic clk,
  // gate drive
  input wire logic [5:0] pwm_out,
  // bench controls
  input wire logic trip,
  input wire logic clr,
  // fault back to the pwm block, overlap flags to the bench
  output logic fault_in,
  output logic [2:0] shoot
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fault_in = 1'b0;
    shoot = 3'h0;
  end
  // sense is a clean level; a real stage may latch, the bench releases it
  always @(posedge clk) begin
    fault_in <= trip;
  end
  // both legs on at once would short the supply
  always @(posedge clk) begin
    for (int g = 0; g < 3; g++) begin
      if (clr) begin
        shoot[g] <= 1'b0;
      end else if (pwm_out[2*g] && pwm_out[2*g+1]) begin
        shoot[g] <= 1'b1;
      end
    end
  end
endmodule

// *** test_motion_pwm_module.sv ***
// self-checking bench for the motion pwm top
module test_motion_pwm_module;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic trip = 1'b0;
  logic clr = 1'b0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic fault_in;
  logic [5:0] pwm_out;
  logic [2:0] adc_trig;
  logic [2:0] shoot;
  logic [31:0] d;
  logic [31:0] hi;
  logic [31:0] lo;
  int n_errors = 0;
  int compares = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  mpwm_top u_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fault_in(fault_in), .pwm_out(pwm_out), .adc_trig(adc_trig));
  mpwm_stage u_stage (.clk(clk), .pwm_out(pwm_out), .trip(trip), .clr(clr), .fault_in(fault_in), .shoot(shoot));
  task automatic test_done;
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    bus(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask
  // one full high then low span of pin i, sampled away from the edge
  task automatic meas(input int i);
    hi = 0;
    lo = 0;
    @(negedge clk);
    while (pwm_out[i] !== 1'b0) @(negedge clk);
    while (pwm_out[i] !== 1'b1) @(negedge clk);
    while (pwm_out[i] === 1'b1) begin
      hi++;
      @(negedge clk);
    end
    while (pwm_out[i] === 1'b0) begin
      lo++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task automatic t_regs;
    rd(12'h044);
    chk("load", 32'h0000_ffff, d);
    wr(12'h00c, 32'hffff_ffff);
    rd(12'h00c);
    chk("outen", 32'h0000_003f, d);
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100);
    chk("hole", 32'h0000_0000, d);
  endtask
  task automatic t_down;
    wr(12'h044, 32'h0000_0004);
    wr(12'h04c, 32'h0000_0002);
    wr(12'h054, 32'h0000_0083);
    wr(12'h058, 32'h0000_000b);
    wr(12'h040, 32'h0000_0001);
    meas(0);
    chk("down_hi", 32'h0000_0003, hi);
    chk("down_lo", 32'h0000_0002, lo);
    meas(1);
    chk("b_hi", 32'h0000_0001, hi);
    chk("b_lo", 32'h0000_0004, lo);
  endtask
  task automatic t_updown;
    wr(12'h044, 32'h0000_0008);
    wr(12'h054, 32'h0000_00e0);
    wr(12'h058, 32'h0000_00e0);
    wr(12'h068, 32'h0000_0101);
    wr(12'h040, 32'h0000_0003);
    wr(12'h004, 32'h0000_0001);
    meas(0);
    chk("ud_hi", 32'h0000_0004, hi);
    chk("ud_lo", 32'h0000_000c, lo);
    rd(12'h018);
    chk("summary", 32'h0000_0001, d & 32'h0000_0007);
    hi = 0;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk);
      hi = hi + adc_trig[0];
    end
    @(posedge clk);
    chk("trig", 32'h0000_0002, hi);
    wr(12'h010, 32'h0000_0001);
    meas(0);
    chk("inv_hi", 32'h0000_000c, hi);
    wr(12'h010, 32'h0000_0000);
  endtask
  task automatic t_global;
    wr(12'h000, 32'h0000_0001);
    wr(12'h040, 32'h0000_000b);
    wr(12'h04c, 32'h0000_0003);
    rd(12'h04c);
    chk("cmpa_old", 32'h0000_0002, d);
    repeat (40) @(posedge clk);
    rd(12'h018);
    chk("pend", 32'h0001_0000, d & 32'h0007_0000);
    wr(12'h008, 32'h0000_0001);
    repeat (40) @(posedge clk);
    rd(12'h04c);
    chk("cmpa_new", 32'h0000_0003, d);
    meas(0);
    chk("gu_hi", 32'h0000_0006, hi);
  endtask
  task automatic t_fault;
    wr(12'h014, 32'h0000_0001);
    trip <= 1'b1;
    repeat (3) @(posedge clk);
    hi = 0;
    lo = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      hi = hi + pwm_out[0];
      lo = lo + pwm_out[1];
    end
    @(posedge clk);
    chk("a_off", 32'h0000_0000, hi);
    chk("b_runs", 32'h0000_0001, {31'h0, lo > 0});
    rd(12'h018);
    chk("fstat", 32'h0000_0300, d & 32'h0000_0300);
    trip <= 1'b0;
    // let the release reach the pins so the measured span is whole
    repeat (4) @(posedge clk);
    wr(12'h018, 32'h0000_0100);
    rd(12'h018);
    chk("fclr", 32'h0000_0000, d & 32'h0000_0300);
    meas(0);
    chk("resume", 32'h0000_0006, hi);
  endtask
  task automatic t_defer;
    wr(12'h084, 32'h0000_000a);
    wr(12'h094, 32'h0000_0001);
    wr(12'h080, 32'h0000_0005);
    wr(12'h084, 32'h0000_0006);
    rd(12'h084);
    chk("load_old", 32'h0000_000a, d);
    repeat (20) @(posedge clk);
    rd(12'h084);
    chk("load_new", 32'h0000_0006, d);
    meas(2);
    chk("g1_hi", 32'h0000_0007, hi);
    chk("g1_lo", 32'h0000_0007, lo);
    wr(12'h00c, 32'h0000_003b);
    lo = 0;
    for (int k = 0; k < 20; k++) begin
      @(negedge clk);
      lo = lo + pwm_out[2];
    end
    @(posedge clk);
    chk("g1_off", 32'h0000_0000, lo);
    wr(12'h00c, 32'h0000_003f);
  endtask
  task automatic t_dband;
    wr(12'h064, 32'h0000_0001);
    wr(12'h05c, 32'h0000_0001);
    repeat (4) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    meas(0);
    chk("dba", 32'h0000_0001, {31'h0, hi < 6 && hi + lo == 16});
    meas(1);
    chk("dbb", 32'h0000_0001, {31'h0, hi < 10 && hi + lo == 16});
    chk("overlap", 32'h0000_0000, {29'h0, shoot});
  endtask
  // whole run is several hundred cycles; this span of 20000 cycles is far beyond it
  initial begin
    #100000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_down;
    t_updown;
    t_global;
    t_fault;
    t_defer;
    t_dband;
    test_done;
  end
endmodule
